//--- dv/scr_assertions.sv
// Checker for scr_top: port relations backed by shadow register copies.
// Assumes the bind below; shadows follow APB writes as the block does.
`timescale 1ns/1ps
module scr_assertions
  import scr_pkg::*;
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic [7:0]  porta_dir_input,
  input wire logic        wdt_always_on,
  input wire logic        wdt_enable,
  input wire logic        ext_irq_pulse,
  input wire logic        tick_event,
  input wire logic        halt_req,
  input wire logic        halted,
  input wire logic        wake_pulse,
  input wire logic        slow_crystal_osc_run,
  input wire logic [7:0]  porta_pullhigh_on
);
  logic [7:0] sh_a;
  logic       sh_keep;
  logic [1:0] edge_sel;
  assign edge_sel = sh_a[7:6];
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sh_a    <= SCR_RST_CTRL_A;
      sh_keep <= SCR_RST_CTRL_B[0];
    end else if (psel && penable && pwrite) begin
      if (paddr == SCR_OFF_CTRL_A) sh_a <= pwdata[7:0];
      if (paddr == SCR_OFF_CTRL_B) sh_keep <= pwdata[0];
    end
  end
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  a_wdt_key: assert property (
    wdt_enable == (wdt_always_on | (sh_a[3:0] != SCR_KEY_DISABLE)))
    else $error("watchdog enable disagrees with key");
  a_keep_run: assert property (
    slow_crystal_osc_run == (!halted | sh_keep))
    else $error("slow crystal run wrong for halt state");
  a_pull_input: assert property (
    (porta_pullhigh_on & ~porta_dir_input) == 8'h00)
    else $error("pull-high on a pin set as output");
  a_ro_zero: assert property (
    psel && penable && !pwrite && paddr == SCR_OFF_CTRL_B
    |-> prdata[5:1] == 5'h00) else $error("unused bits read nonzero");
  a_edge_off: assert property (
    edge_sel == SCR_EDGE_OFF && $past(edge_sel) == SCR_EDGE_OFF
    |-> !ext_irq_pulse) else $error("edge pulse while disabled");
  a_tick_gap: assert property (
    tick_event |=> !tick_event [*8])
    else $error("time base events too close");
  a_halt_enter: assert property (
    halt_req && !halted |-> ##[1:2] halted)
    else $error("halt request not taken");
  a_wake_run: assert property (
    wake_pulse |-> !halted && $past(halted))
    else $error("wake pulse without leaving halt");
endmodule

bind scr_top scr_assertions scr_assertions_i (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
  .porta_dir_input, .wdt_always_on, .wdt_enable, .ext_irq_pulse,
  .tick_event, .halt_req, .halted, .wake_pulse, .slow_crystal_osc_run,
  .porta_pullhigh_on);

//--- dv/tb_top.sv
// Bench for scr_top: APB traffic, pin routing, events, halt and wake.
// Assumes a zero-wait APB slave and the register map of scr_pkg.
`timescale 1ns/1ps
module tb_top
  import scr_pkg::*;
;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
  logic        fdsrc, aon, losc, tsrc, pwm, hreq, t0, t1, ext_p, wdt_en;
  logic        wd_t, tick, halted, wake, xrun, err_v, tsrc_run;
  logic [7:0]  paddr, dir_in, pu_on;
  logic [31:0] pwdata, prdata, pins, rd_v, v, seed;
  wire  [31:0] oe, fo;
  int          n_fail = 0, cmp_count = 0, n_ext = 0, n_wd = 0, k;

  scr_top scr_top_i (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .irq, .porta_pins(pins[31:24]),
    .portc_pins(pins[23:16]), .portb_pins(pins[15:8]),
    .porte_pins(pins[7:0]), .porta_dir_input(dir_in),
    .freq_divider_src(fdsrc), .porta_fn_oe(oe[31:24]),
    .portc_fn_oe(oe[23:16]), .portb_fn_oe(oe[15:8]), .porte_fn_oe(oe[7:0]),
    .porta_fn_out(fo[31:24]), .portc_fn_out(fo[23:16]),
    .portb_fn_out(fo[15:8]), .porte_fn_out(fo[7:0]),
    .timer0_ext_clock_in(t0), .timer1_ext_clock_in(t1),
    .ext_irq_pulse(ext_p), .wdt_always_on(aon), .wdt_enable(wdt_en),
    .low_osc_clk(losc), .watchdog_tick(wd_t), .tick_source_clock(tsrc),
    .pwm_out_selected(pwm), .tick_event(tick), .halt_req(hreq), .halted,
    .wake_pulse(wake), .slow_crystal_osc_run(xrun),
    .porta_pullhigh_on(pu_on));

  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    n_ext <= n_ext + ext_p;
    n_wd  <= n_wd + wd_t;
    // Tick source toggles each edge while enabled, so it rises every 2 edges
    tsrc  <= tsrc_run & ~tsrc;
  end

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // Bit of {A,C,B,E} pins for group g, function f (freq, t0, int, t1)
  function automatic int pin(int g, int f);
    return (g == 0) ? 25 + f : (g == 1) ? 21 - f : (3 - g) * 8 + f;
  endfunction
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, exp, input string m);
    cmp_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED %0t %s", $time, m);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask
  // Bounded wait; leaves the number of edges waited in k
  task automatic wait_for(ref logic s);
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (s !== 1'b1 && k < 20000);
    if (s !== 1'b1) begin
      chk(s, 1'b1, "wait ran out");
      end_of_test();
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, logic [31:0] d);
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    wait_for(pready);
    rd_v  = prdata;
    err_v = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  // Extra edge lets registered outputs settle before the caller looks
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
    cyc(1);
  endtask
  task automatic rdc(input logic [7:0] a, logic [31:0] e, string m);
    apb(1'b0, a, 32'h0);
    chk(rd_v, e, m);
  endtask
  task automatic halt();
    hreq <= 1'b1;
    cyc(1);
    hreq <= 1'b0;
    cyc(3);
  endtask

  initial begin
    seed = 32'h00007984;
    {presetn, psel, penable, pwrite, fdsrc, aon, losc, tsrc_run, pwm, hreq} =
      '0;
    {paddr, dir_in, pwdata, pins} = '0;
    cyc(3);
    presetn <= 1'b1;
    rdc(SCR_OFF_CTRL_A, 32'h8a, "first control reset");
    rdc(SCR_OFF_CTRL_B, 32'h01, "second control reset");
    chk(wdt_en, 1'b0, "watchdog reset state");
    for (int i = 0; i < 10; i++) begin
      v = rnd() & 32'hff;
      if (i < 3) v = (i == 0) ? 32'h0a : (i == 1) ? 32'h05 : 32'hca;
      aon <= v[7] ^ v[0];
      wr(SCR_OFF_CTRL_A, v);
      rdc(SCR_OFF_CTRL_A, v, "first control readback");
      chk(wdt_en, aon | (v[3:0] != 4'ha), "watchdog enable");
    end
    fdsrc <= 1'b1;
    for (int g = 0; g < 4; g++) begin
      v = (rnd() & 32'h3f) | (g << 6);
      wr(SCR_OFF_CTRL_B, v);
      rdc(SCR_OFF_CTRL_B, v & 32'hc1, "unused bits");
      chk(oe, 32'h1 << pin(g, 0), "frequency lane enable");
      chk(fo, 32'h1 << pin(g, 0), "frequency lane data");
      pins <= 32'h1 << pin(g, 1);
      cyc(4);
      chk({t0, t1}, 2'b10, "timer0 input routing");
      pins <= 32'h1 << pin(g, 3);
      cyc(4);
      chk({t0, t1}, 2'b01, "timer1 input routing");
    end
    for (int e = 0; e < 4; e++) begin
      wr(SCR_OFF_CTRL_A, (e << 6) | 32'h05);
      k = n_ext;
      pins <= 32'h4;
      cyc(8);
      chk(n_ext - k, e & 1, "rising edge pulses");
      k = n_ext;
      pins <= 32'h0;
      cyc(8);
      chk(n_ext - k, e >> 1, "falling edge pulses");
    end
    rdc(SCR_OFF_IRQ_STAT, 32'h1, "edge status sticky");
    chk(irq, 1'b0, "masked interrupt");
    wr(SCR_OFF_IRQ_MASK, 32'h1);
    chk(irq, 1'b1, "unmasked interrupt");
    wr(SCR_OFF_IRQ_STAT, 32'h1);
    rdc(SCR_OFF_IRQ_STAT, 32'h0, "status cleared");
    chk(irq, 1'b0, "interrupt cleared");
    pwm <= 1'b1;
    for (int c = 0; c < 4; c++) begin
      wr(SCR_OFF_CTRL_A, (c << 4) | 32'h05);
      wait_for(tick);
      wait_for(tick);
      chk(k, 32'h400 << c, "time base period");
    end
    pwm <= 1'b0;
    tsrc_run <= 1'b1;
    wr(SCR_OFF_CTRL_A, 32'h05);
    wait_for(tick);
    wait_for(tick);
    chk(k, 32'h800, "tick source period");
    tsrc_run <= 1'b0;
    k = n_wd;
    repeat (4) begin
      losc <= 1'b1;
      cyc(4);
      losc <= 1'b0;
      cyc(4);
    end
    cyc(4);
    chk(n_wd - k, 32'h4, "watchdog clock ticks");
    repeat (4) begin
      v = rnd();
      dir_in <= v[15:8];
      wr(SCR_OFF_PULLHIGH, v);
      chk(pu_on, v[7:0] & v[15:8], "pull-high gating");
    end
    apb(1'b0, 8'h20, 32'h0);
    chk({err_v, rd_v[30:0]}, 32'h80000000, "unmapped read refused");
    wr(SCR_OFF_CTRL_B, 32'h0);
    wr(SCR_OFF_WAKE_A, 32'h1);
    pins <= 32'h03000000;
    cyc(4);
    halt();
    chk({halted, xrun}, 2'b10, "halt stops slow crystal");
    pins <= 32'h01000000;
    cyc(8);
    chk(halted, 1'b1, "disabled pin keeps halt");
    pins <= 32'h0;
    wait_for(wake);
    cyc(1);
    chk(halted, 1'b0, "enabled pin wakes");
    wr(SCR_OFF_CTRL_B, 32'h1);
    halt();
    chk({halted, xrun}, 2'b11, "halt keeps slow crystal");
    end_of_test();
  end
endmodule

//--- src/scr_pkg.sv
// Package for the system control register block: offsets, fields, resets.
// Assumes a 32-bit APB master and word-aligned register offsets.
package scr_pkg;

  localparam logic [7:0] SCR_OFF_CTRL_A    = 8'h00;
  localparam logic [7:0] SCR_OFF_CTRL_B    = 8'h04;
  localparam logic [7:0] SCR_OFF_WAKE_A    = 8'h08;
  localparam logic [7:0] SCR_OFF_WAKE_C    = 8'h0c;
  localparam logic [7:0] SCR_OFF_PULLHIGH  = 8'h10;
  localparam logic [7:0] SCR_OFF_IRQ_STAT  = 8'h14;
  localparam logic [7:0] SCR_OFF_IRQ_MASK  = 8'h18;
  localparam logic [7:0] SCR_OFF_STATE     = 8'h1c;

  localparam logic [7:0] SCR_RST_CTRL_A    = 8'h8a;
  localparam logic [7:0] SCR_RST_CTRL_B    = 8'h01;
  localparam logic [7:0] SCR_RST_ZERO      = 8'h00;

  // First register fields
  localparam int SCR_EDGE_POS   = 6;
  localparam int SCR_PERIOD_POS = 4;
  localparam int SCR_KEY_POS    = 0;
  localparam logic [3:0] SCR_KEY_DISABLE   = 4'ha;
  // Second register fields
  localparam int SCR_GROUP_POS  = 6;
  localparam int SCR_KEEP_POS   = 0;
  localparam logic [7:0] SCR_CTRL_B_MASK   = 8'hc1;

  localparam logic [1:0] SCR_EDGE_OFF      = 2'h0;
  localparam logic [1:0] SCR_EDGE_RISE     = 2'h1;
  localparam logic [1:0] SCR_EDGE_FALL     = 2'h2;
  localparam logic [1:0] SCR_EDGE_BOTH     = 2'h3;

  localparam logic [1:0] SCR_GRP_A         = 2'h0;
  localparam logic [1:0] SCR_GRP_C         = 2'h1;
  localparam logic [1:0] SCR_GRP_B         = 2'h2;
  localparam logic [1:0] SCR_GRP_E         = 2'h3;

  // Shortest period is 2^10 ticks
  localparam int SCR_TICK_BASE_LOG = 10;
  localparam int SCR_TICK_WIDTH    = 13;

  localparam int SCR_IRQ_EDGE  = 0;
  localparam int SCR_IRQ_TICK  = 1;
  localparam int SCR_IRQ_WAKE  = 2;
  localparam int SCR_IRQ_COUNT = 3;

  typedef enum logic {
    SCR_RUN,
    SCR_HALT
  } scr_mode_type;

endpackage

//--- src/scr_top.sv
// System control registers: edge select, tick period, watchdog key,
// pin group routing, halt handling, wake-up and pull-high enables.
// Assumes port pins and oscillator pins are asynchronous to pclk; core
// signals (halt request, direction, modulator select) share pclk.
`timescale 1ns/1ps

// What this block does
// [RQ1] The edge field picks none, rising, falling or both edges of the pin.
// [RQ2] The period field picks 2^10 to 2^13 tick-source periods.
// [RQ3] The watchdog is off only when the key holds 1010.
// [RQ4] Software is advised to write 0101 to the key to enable the watchdog.
// [RQ5] With the always-on option the key has no effect.
// [RQ6] The group field routes the four shared pins to port A, C, B or E.
// [RQ7] On halt the slow crystal stops unless the keep bit is one.
// [RQ8] Bits 5 to 1 of the second register read as zero.
// [RQ9] While halted a falling edge on an enabled A or C pin wakes the core; the code only wakes on pins 0 to 3 of A and C.
// [RQ10] Pull-high connects only to enabled pins set as inputs.
// [RQ11] Oscillator clocks feed the watchdog and the time base.
// [RQ12] The tick source is the system clock while a modulator is selected.
// [RQ13] The interrupt pin is synchronised and edges give one-cycle pulses.
// [RQ14] The time base pulses once each completed selected period.
module scr_top
  import scr_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             irq,
  input  wire logic [7:0]  porta_pins,
  input  wire logic [7:0]  portb_pins,
  input  wire logic [7:0]  portc_pins,
  input  wire logic [7:0]  porte_pins,
  input  wire logic [7:0]  porta_dir_input,
  input  wire logic        freq_divider_src,
  output logic [7:0]       porta_fn_out,
  output logic [7:0]       porta_fn_oe,
  output logic [7:0]       portb_fn_out,
  output logic [7:0]       portb_fn_oe,
  output logic [7:0]       portc_fn_out,
  output logic [7:0]       portc_fn_oe,
  output logic [7:0]       porte_fn_out,
  output logic [7:0]       porte_fn_oe,
  output logic             timer0_ext_clock_in,
  output logic             timer1_ext_clock_in,
  output logic             ext_irq_pulse,
  input  wire logic        wdt_always_on,
  output logic             wdt_enable,
  input  wire logic        low_osc_clk,
  output logic             watchdog_tick,
  input  wire logic        tick_source_clock,
  input  wire logic        pwm_out_selected,
  output logic             tick_event,
  input  wire logic        halt_req,
  output logic             halted,
  output logic             wake_pulse,
  output logic             slow_crystal_osc_run,
  output logic [7:0]       porta_pullhigh_on
);

  typedef struct packed {
    logic [7:0]               ctrl_a;
    logic [7:0]               ctrl_b;
    logic [7:0]               wake_a;
    logic [7:0]               wake_c;
    logic [7:0]               pullhigh;
    logic [SCR_IRQ_COUNT-1:0] irq_stat;
    logic [SCR_IRQ_COUNT-1:0] irq_mask;
    logic [7:0]               pa_s1;
    logic [7:0]               pa_s2;
    logic [7:0]               pb_s1;
    logic [7:0]               pb_s2;
    logic [7:0]               pc_s1;
    logic [7:0]               pc_s2;
    logic [7:0]               pe_s1;
    logic [7:0]               pe_s2;
    logic [7:0]               wake_prev;
    logic                     int_prev;
    logic [1:0]               osc_s;
    logic                     osc_prev;
    logic [1:0]               tsrc_s;
    logic                     tsrc_prev;
    logic [SCR_TICK_WIDTH-1:0] tick_cnt;
    logic                     tick_evt;
    logic                     edge_evt;
    logic                     wdt_tick;
    logic                     wake_evt;
    scr_mode_type             mode;
    logic [31:0]              rdata;
  } scr_state_type;

  scr_state_type state;
  scr_state_type next_state;

  // One-hot lane for a pin index
  function automatic logic [7:0] scr_lane(input logic [2:0] idx);
    scr_lane = 8'h01 << idx;
  endfunction

  // Pick a pin from the synchronised port selected by the group field
  function automatic logic scr_pick(input logic [1:0] grp,
                                    input logic [7:0] pa,
                                    input logic [7:0] pb,
                                    input logic [7:0] pc,
                                    input logic [7:0] pe,
                                    input logic [2:0] ia,
                                    input logic [2:0] ic,
                                    input logic [2:0] ib,
                                    input logic [2:0] ie);
    case (grp)
      SCR_GRP_A: scr_pick = pa[ia];
      SCR_GRP_C: scr_pick = pc[ic];
      SCR_GRP_B: scr_pick = pb[ib];
      default:   scr_pick = pe[ie];
    endcase
  endfunction

  logic [1:0]  edge_sel;
  logic [1:0]  period_sel;
  logic [3:0]  wdt_key;
  logic [1:0]  pin_group;
  logic        keep_bit;
  logic        int_pin;
  logic        int_rise;
  logic        int_fall;
  logic        tick_step;
  logic        tick_wrap;
  logic [SCR_TICK_WIDTH-1:0] tick_top;
  logic        wr_en;
  logic        rd_en;
  logic        mapped;
  logic [7:0]  wake_fall;
  logic [SCR_IRQ_COUNT-1:0] irq_set;
  logic [SCR_IRQ_COUNT-1:0] irq_clr;

  assign edge_sel   = state.ctrl_a[SCR_EDGE_POS +: 2];
  assign period_sel = state.ctrl_a[SCR_PERIOD_POS +: 2];
  assign wdt_key    = state.ctrl_a[SCR_KEY_POS +: 4];
  assign pin_group  = state.ctrl_b[SCR_GROUP_POS +: 2];
  assign keep_bit   = state.ctrl_b[SCR_KEEP_POS];

  assign wr_en = psel & penable & pwrite;
  assign rd_en = psel & ~pwrite;
  always_comb begin
    case (paddr)
      SCR_OFF_CTRL_A, SCR_OFF_CTRL_B, SCR_OFF_WAKE_A, SCR_OFF_WAKE_C,
      SCR_OFF_PULLHIGH, SCR_OFF_IRQ_STAT, SCR_OFF_IRQ_MASK,
      SCR_OFF_STATE: mapped = 1'b1;
      default:       mapped = 1'b0;
    endcase
  end

  // Interrupt pin: PA3, PC3, PB2 or PE2 by group
  assign int_pin = scr_pick(pin_group, state.pa_s2, state.pb_s2,
                            state.pc_s2, state.pe_s2,
                            3'h3, 3'h3, 3'h2, 3'h2);               // [RQ6]
  assign int_rise = int_pin & ~state.int_prev;                    // [RQ13]
  assign int_fall = ~int_pin & state.int_prev;                    // [RQ13]

  // Source edge only counts once synchronised; system clock otherwise
  assign tick_step = pwm_out_selected |
                     (state.tsrc_s[1] & ~state.tsrc_prev);         // [RQ12]
  assign tick_top  = SCR_TICK_WIDTH'((1 << (SCR_TICK_BASE_LOG +
                                       int'(period_sel))) - 1);    // [RQ2]
  assign tick_wrap = tick_step &&
                     ((state.tick_cnt & tick_top) == tick_top);    // [RQ14]

  assign wake_fall = state.wake_prev & ~{state.pc_s2[3:0], state.pa_s2[3:0]};

  always_comb begin
    next_state = state;
    irq_set    = '0;
    irq_clr    = '0;

    next_state.pa_s1 = porta_pins;
    next_state.pa_s2 = state.pa_s1;
    next_state.pb_s1 = portb_pins;
    next_state.pb_s2 = state.pb_s1;
    next_state.pc_s1 = portc_pins;
    next_state.pc_s2 = state.pc_s1;
    next_state.pe_s1 = porte_pins;
    next_state.pe_s2 = state.pe_s1;
    next_state.int_prev  = int_pin;
    next_state.osc_s     = {state.osc_s[0], low_osc_clk};
    next_state.osc_prev  = state.osc_s[1];
    next_state.tsrc_s    = {state.tsrc_s[0], tick_source_clock};
    next_state.tsrc_prev = state.tsrc_s[1];
    next_state.wake_prev = {state.pc_s2[3:0], state.pa_s2[3:0]};

    // Edge decode
    case (edge_sel)
      SCR_EDGE_RISE: next_state.edge_evt = int_rise;              // [RQ1]
      SCR_EDGE_FALL: next_state.edge_evt = int_fall;              // [RQ1]
      SCR_EDGE_BOTH: next_state.edge_evt = int_rise | int_fall;   // [RQ1]
      default:       next_state.edge_evt = 1'b0;                  // [RQ1]
    endcase

    // Time base
    next_state.tick_evt = tick_wrap;                              // [RQ14]
    if (tick_step) begin
      next_state.tick_cnt = state.tick_cnt + 1'b1;                // [RQ14]
    end

    // Watchdog clock from the low-speed oscillator
    next_state.wdt_tick = state.osc_s[1] & ~state.osc_prev;       // [RQ11]

    // Halt and wake; only the low four pins of A and C are wake sources
    next_state.wake_evt = 1'b0;
    case (state.mode)
      SCR_RUN: begin
        if (halt_req) begin
          next_state.mode = SCR_HALT;
        end
      end
      SCR_HALT: begin
        if (|(wake_fall & {state.wake_c[3:0], state.wake_a[3:0]})) begin
          next_state.mode     = SCR_RUN;                          // [RQ9]
          next_state.wake_evt = 1'b1;                             // [RQ9]
        end
      end
      default: next_state.mode = SCR_RUN;
    endcase

    // Register writes
    if (wr_en) begin
      case (paddr)
        SCR_OFF_CTRL_A:   next_state.ctrl_a   = pwdata[7:0];
        SCR_OFF_CTRL_B:   next_state.ctrl_b   = pwdata[7:0] &
                                                SCR_CTRL_B_MASK;  // [RQ8]
        SCR_OFF_WAKE_A:   next_state.wake_a   = pwdata[7:0];
        SCR_OFF_WAKE_C:   next_state.wake_c   = pwdata[7:0];
        SCR_OFF_PULLHIGH: next_state.pullhigh = pwdata[7:0];
        SCR_OFF_IRQ_STAT: irq_clr = pwdata[SCR_IRQ_COUNT-1:0];
        SCR_OFF_IRQ_MASK: next_state.irq_mask =
                            pwdata[SCR_IRQ_COUNT-1:0];
        default: ;
      endcase
    end

    // Set wins over a same-cycle clear
    irq_set[SCR_IRQ_EDGE] = state.edge_evt;
    irq_set[SCR_IRQ_TICK] = state.tick_evt;
    irq_set[SCR_IRQ_WAKE] = state.wake_evt;
    next_state.irq_stat = (state.irq_stat & ~irq_clr) | irq_set;

    // Read data registered during setup so it is ready at access
    next_state.rdata = '0;
    if (rd_en) begin
      case (paddr)
        SCR_OFF_CTRL_A:   next_state.rdata[7:0] = state.ctrl_a;
        SCR_OFF_CTRL_B:   next_state.rdata[7:0] = state.ctrl_b &
                                                  SCR_CTRL_B_MASK; // [RQ8]
        SCR_OFF_WAKE_A:   next_state.rdata[7:0] = state.wake_a;
        SCR_OFF_WAKE_C:   next_state.rdata[7:0] = state.wake_c;
        SCR_OFF_PULLHIGH: next_state.rdata[7:0] = state.pullhigh;
        SCR_OFF_IRQ_STAT: next_state.rdata[SCR_IRQ_COUNT-1:0] =
                            state.irq_stat;
        SCR_OFF_IRQ_MASK: next_state.rdata[SCR_IRQ_COUNT-1:0] =
                            state.irq_mask;
        SCR_OFF_STATE:    next_state.rdata[3:0] =
                            {slow_crystal_osc_run, pin_group != 2'h0,
                             state.mode == SCR_HALT, wdt_enable};
        default: ;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state          <= '0;
      state.ctrl_a   <= SCR_RST_CTRL_A;
      state.ctrl_b   <= SCR_RST_CTRL_B;
      state.wake_a   <= SCR_RST_ZERO;
      state.wake_c   <= SCR_RST_ZERO;
      state.pullhigh <= SCR_RST_ZERO;
      state.mode     <= SCR_RUN;
    end else begin
      state <= next_state;
    end
  end

  // Bus answers; reads take the access cycle, so data was latched at setup
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~mapped;
  assign prdata  = state.rdata;
  assign irq     = |(state.irq_stat & state.irq_mask);

  // Keeps the watchdog running whenever the option forces it
  assign wdt_enable = wdt_always_on |
                      (wdt_key != SCR_KEY_DISABLE);               // [RQ3] [RQ5]

  assign halted               = state.mode == SCR_HALT;
  assign slow_crystal_osc_run = ~halted | keep_bit;               // [RQ7]
  assign wake_pulse           = state.wake_evt;
  assign ext_irq_pulse        = state.edge_evt;                   // [RQ13]
  assign tick_event           = state.tick_evt;                   // [RQ14]
  assign watchdog_tick        = state.wdt_tick;                   // [RQ11]
  assign porta_pullhigh_on    = state.pullhigh & porta_dir_input; // [RQ10]

  // Timer clocks: PA2/PC4/PB1/PE1 and PA4/PC2/PB3/PE3
  assign timer0_ext_clock_in = scr_pick(pin_group, state.pa_s2,
                                        state.pb_s2, state.pc_s2,
                                        state.pe_s2,
                                        3'h2, 3'h4, 3'h1, 3'h1);  // [RQ6]
  assign timer1_ext_clock_in = scr_pick(pin_group, state.pa_s2,
                                        state.pb_s2, state.pc_s2,
                                        state.pe_s2,
                                        3'h4, 3'h2, 3'h3, 3'h3);  // [RQ6]

  // Frequency output lane: PA1, PC5, PB0 or PE0
  assign porta_fn_oe  = (pin_group == SCR_GRP_A) ? scr_lane(3'h1) : 8'h00;
  assign portc_fn_oe  = (pin_group == SCR_GRP_C) ? scr_lane(3'h5) : 8'h00;
  assign portb_fn_oe  = (pin_group == SCR_GRP_B) ? scr_lane(3'h0) : 8'h00;
  assign porte_fn_oe  = (pin_group == SCR_GRP_E) ? scr_lane(3'h0) : 8'h00;
  assign porta_fn_out = porta_fn_oe & {8{freq_divider_src}};      // [RQ6]
  assign portb_fn_out = portb_fn_oe & {8{freq_divider_src}};      // [RQ6]
  assign portc_fn_out = portc_fn_oe & {8{freq_divider_src}};      // [RQ6]
  assign porte_fn_out = porte_fn_oe & {8{freq_divider_src}};      // [RQ6]

endmodule
